// ---- logic/acs_pkg.sv ----
// constants shared by the serial configuration port
// assumes: core clock 200 MHz, link clock from the external master
package acs_pkg;

  // master keeps sclk at or below the sample rate over this divisor
  localparam int unsigned SCLK_RATE_DIV  = 16;

  // register byte offsets inside the 13-bit address space
  localparam logic [12:0] ADDR_PORT_SETUP = 13'h0000;
  localparam logic [12:0] ADDR_BURST_END  = 13'h0002;
  localparam logic [12:0] ADDR_POWER_SEL  = 13'h0025;
  localparam logic [12:0] ADDR_OUT_FORMAT = 13'h0073;

  // reset values
  localparam logic [7:0] PORT_SETUP_RST = 8'h18;
  localparam logic [7:0] BURST_END_RST  = 8'hFF;
  localparam logic [2:0] POWER_SEL_RST  = 3'h0;
  localparam logic [7:0] OUT_FORMAT_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // serial_port_setup field positions
  localparam int unsigned PS_FOUR_WIRE_BIT = 7;
  localparam int unsigned PS_LSB_FIRST_BIT = 6;
  localparam int unsigned PS_SOFT_RST_BIT  = 5;

  // instruction word layout
  localparam int unsigned INSTR_READ_BIT = 15;
  localparam int unsigned INSTR_CNT_HI   = 14;
  localparam int unsigned INSTR_CNT_LO   = 13;
  localparam int unsigned ADDR_W         = 13;
  localparam logic [1:0]  CNT_BURST      = 2'h3;

  // power-down select codes
  localparam logic [2:0] PWR_SEL_PIN    = 3'h0;
  localparam logic [2:0] PWR_SEL_NORMAL = 3'h1;
  localparam logic [2:0] PWR_SEL_NAP    = 3'h2;
  localparam logic [2:0] PWR_SEL_SLEEP  = 3'h4;

  // power state codes, same coding as the tri-level pin
  localparam logic [1:0] PWR_ST_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ST_SLEEP  = 2'h1;
  localparam logic [1:0] PWR_ST_NAP    = 2'h2;

  typedef enum logic [1:0] {
    ST_INSTR_FIRST,
    ST_INSTR_SECOND,
    ST_DATA
  } acs_phase_type;

  // bit reversal for lsb-first ordering
  function automatic logic [7:0] acs_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = {<<{v}};
    return r;
  endfunction

endpackage

// ---- logic/acs_sync3.sv ----
// three-stage synchroniser; output moves when stages two and three agree
// assumes: d_in is asynchronous to clk_in
`timescale 1ns/1ps
module acs_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  // stage one feeds only stage two
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      q_ff  <= RST_VAL;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q_ff <= s3_ff;
      end
    end
  end

  assign q_out = q_ff;
endmodule

// ---- logic/acs_link_shift.sv ----
// link-clock shifter: gathers bytes on rising sclk, launches on falling
// assumes: sclk stands still outside frames; chip select high clears the bit count and shifters
`timescale 1ns/1ps
module acs_link_shift (
  input  wire logic       link_sclk_in,
  input  wire logic       link_clr_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       sdio_in,
  input  wire logic [7:0] rd_word_in,
  input  wire logic       rd_drive_in,
  output logic      [7:0] rx_byte_out,
  output logic            byte_tgl_out,
  output logic            tx_bit_out,
  output logic            drive_out
);
  logic       link_rst;
  logic [2:0] bit_cnt_ff;
  logic [6:0] rx_sh_ff;
  logic [7:0] rx_byte_ff;
  logic       byte_tgl_ff;
  logic [7:0] tx_ff;
  logic       drive_ff;
  logic       byte_last;

  // frame clear: chip select high or core reset
  assign link_rst  = chip_select_n_in | link_clr_in;
  assign byte_last = (bit_cnt_ff == 3'h7);

  // first rise after select is bit zero of the instruction
  always_ff @(posedge link_sclk_in or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_ff <= 3'h0;
      rx_sh_ff   <= 7'h00;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      rx_sh_ff   <= {rx_sh_ff[5:0], sdio_in};
    end
  end

  // whole byte handed over with a toggle
  always_ff @(posedge link_sclk_in or posedge link_clr_in) begin
    if (link_clr_in) begin
      rx_byte_ff  <= 8'h00;
      byte_tgl_ff <= 1'b0;
    end else if (byte_last) begin
      rx_byte_ff  <= {rx_sh_ff, sdio_in};
      byte_tgl_ff <= ~byte_tgl_ff;
    end
  end

  // read data launched on falling edges, loaded at byte boundaries
  always_ff @(negedge link_sclk_in or posedge link_rst) begin
    if (link_rst) begin
      tx_ff    <= 8'h00;
      drive_ff <= 1'b0;
    end else if (bit_cnt_ff == 3'h0) begin
      tx_ff    <= rd_word_in;
      drive_ff <= rd_drive_in;
    end else begin
      tx_ff    <= {tx_ff[6:0], 1'b0};
    end
  end

  a_byte_handover: assert property (
    @(posedge link_sclk_in) disable iff (link_rst)
    byte_last |=> (byte_tgl_ff != $past(byte_tgl_ff))
  ) else $error("byte toggle missed after eighth bit");

  assign rx_byte_out  = rx_byte_ff;
  assign byte_tgl_out = byte_tgl_ff;
  assign tx_bit_out   = tx_ff[7];
  assign drive_out    = drive_ff;
endmodule

// ---- logic/acs_core.sv ----
// serial configuration slave: instruction decode, registers, pin control
// assumes: external master clocks link_sclk_in; pins arrive asynchronously
//
// How it works
// - default three-wire, data pin turns automatically
// - setup bit 7 enables dedicated read output
// - slave only, master starts every transfer
// - first rise after select starts instruction
// - msb first; setup bit 6 selects lsb
// - address steps up msb-first, down lsb-first
// - leading instruction bit high means read
// - next two bits give byte count
// - low thirteen bits give start address
// - bytes continue while selected and clocked
// - short transfers keep state across pauses
// - long transfer ends on late deselect
// - output format register steers output mode
// - serial power mode overrides the pin
// - soft reset restores defaults, power kept
// - burst end register closes long bursts
`timescale 1ns/1ps
module acs_core (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       link_sclk_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe_n_out,
  output logic            dedicated_serial_out_out,
  output logic            dedicated_serial_out_oe_n_out,
  input  wire logic [1:0] power_mode_pin_in,
  output logic      [1:0] power_state_out,
  output logic      [7:0] output_format_out
);
  import acs_pkg::*;

  acs_phase_type state_ff;
  acs_phase_type nxt_state;

  logic              link_clr_ff;
  logic [7:0]        rx_byte;
  logic              byte_tgl;
  logic              tx_bit;
  logic              link_drive;
  logic [3:0]        async_bits;
  logic [3:0]        sync_bits;
  logic              cs_n_sync;
  logic              tgl_sync;
  logic [1:0]        pin_sync;
  logic              cs_n_prev_ff;
  logic              tgl_prev_ff;
  logic              byte_ev;
  logic              cs_rise;

  logic [7:0]        port_setup_ff;
  logic [7:0]        burst_end_ff;
  logic [2:0]        power_sel_ff;
  logic [7:0]        out_fmt_ff;
  logic [1:0]        power_state_ff;
  logic [1:0]        nxt_power_state;

  logic [7:0]        first_ff;
  logic [7:0]        nxt_first;
  logic              dir_rd_ff;
  logic              nxt_dir_rd;
  logic [1:0]        cnt_ff;
  logic [1:0]        nxt_cnt;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [1:0]        done_ff;
  logic [1:0]        nxt_done;
  logic [7:0]        rd_word_ff;
  logic [7:0]        nxt_rd_word;
  logic              rd_drive_ff;
  logic              nxt_rd_drive;

  logic              four_wire;
  logic              lsb_first;
  logic [7:0]        in_byte;
  logic [15:0]       instr_word;
  logic [ADDR_W-1:0] step_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_val;
  logic [7:0]        rd_load;
  logic              xfer_last;
  logic              wr_en;
  logic              hit_setup;
  logic              hit_burst;
  logic              hit_power;
  logic              hit_format;
  logic              rd_setup;
  logic              rd_burst;
  logic              rd_power;
  logic              rd_format;
  logic              soft_rst;
  logic              burst_abort;

  // link-side shifter; bit and byte timing lives on the master's clock
  acs_link_shift u_link (
    .link_sclk_in     (link_sclk_in),
    .link_clr_in      (link_clr_ff),
    .chip_select_n_in (chip_select_n_in),
    .sdio_in          (sdio_in),
    .rd_word_in       (rd_word_ff),
    .rd_drive_in      (rd_drive_ff),
    .rx_byte_out      (rx_byte),
    .byte_tgl_out     (byte_tgl),
    .tx_bit_out       (tx_bit),
    .drive_out        (link_drive)
  );

  // link clear held while the core is in reset
  always_ff @(posedge core_clk_in) begin
    link_clr_ff <= ~rst_n_in;
  end

  // pins and the byte toggle enter the core domain here
  assign async_bits = {power_mode_pin_in, byte_tgl, chip_select_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      acs_sync3 #(.RST_VAL(gi == 0)) u_sync (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (async_bits[gi]),
        .q_out    (sync_bits[gi])
      );
    end
  endgenerate

  assign cs_n_sync = sync_bits[0];
  assign tgl_sync  = sync_bits[1];
  assign pin_sync  = sync_bits[3:2];

  // edge history of the synchronised levels
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cs_n_prev_ff <= 1'b1;
      tgl_prev_ff  <= 1'b0;
    end else begin
      cs_n_prev_ff <= cs_n_sync;
      tgl_prev_ff  <= tgl_sync;
    end
  end

  assign byte_ev = tgl_sync ^ tgl_prev_ff;
  assign cs_rise = cs_n_sync & ~cs_n_prev_ff;

  // bit order and wire mode come from the setup register
  assign four_wire = port_setup_ff[PS_FOUR_WIRE_BIT];
  assign lsb_first = port_setup_ff[PS_LSB_FIRST_BIT];
  assign in_byte   = lsb_first ? acs_rev8(rx_byte) : rx_byte;
  assign instr_word = lsb_first ? {in_byte, first_ff}
                                : {first_ff, in_byte};

  // address walks up or down with the bit order
  assign step_addr = lsb_first ? (addr_ff - 13'h0001)
                               : (addr_ff + 13'h0001);

  // write decode at the current address
  assign wr_en      = byte_ev & (state_ff == ST_DATA) & ~dir_rd_ff;
  assign hit_setup  = wr_en & (addr_ff == ADDR_PORT_SETUP);
  assign hit_burst  = wr_en & (addr_ff == ADDR_BURST_END);
  assign hit_power  = wr_en & (addr_ff == ADDR_POWER_SEL);
  assign hit_format = wr_en & (addr_ff == ADDR_OUT_FORMAT);
  assign soft_rst   = hit_setup & in_byte[PS_SOFT_RST_BIT];

  // read decode at the address of the next byte to send
  assign rd_addr   = (state_ff == ST_INSTR_SECOND)
                     ? instr_word[ADDR_W-1:0] : step_addr;
  assign rd_setup  = (rd_addr == ADDR_PORT_SETUP);
  assign rd_burst  = (rd_addr == ADDR_BURST_END);
  assign rd_power  = (rd_addr == ADDR_POWER_SEL);
  assign rd_format = (rd_addr == ADDR_OUT_FORMAT);
  assign rd_val    = rd_setup  ? port_setup_ff :
                     rd_burst  ? burst_end_ff :
                     rd_power  ? {5'h00, power_sel_ff} :
                     rd_format ? out_fmt_ff : UNMAPPED_READ;
  assign rd_load   = lsb_first ? acs_rev8(rd_val) : rd_val;

  // short counts end on the byte count, long ones at the burst end
  assign xfer_last = (cnt_ff == CNT_BURST)
                     ? (addr_ff[7:0] == burst_end_ff)
                     : (done_ff == cnt_ff);
  assign burst_abort = cs_rise & (cnt_ff == CNT_BURST)
                       & (done_ff != 2'h0);

  // transfer sequencing, advanced once per received byte
  always_comb begin
    nxt_state    = state_ff;
    nxt_first    = first_ff;
    nxt_dir_rd   = dir_rd_ff;
    nxt_cnt      = cnt_ff;
    nxt_addr     = addr_ff;
    nxt_done     = done_ff;
    nxt_rd_word  = rd_word_ff;
    nxt_rd_drive = rd_drive_ff;
    unique case (state_ff)
      ST_INSTR_FIRST: begin
        if (byte_ev) begin
          nxt_first = in_byte;
          nxt_state = ST_INSTR_SECOND;
        end
      end
      ST_INSTR_SECOND: begin
        if (byte_ev) begin
          nxt_dir_rd   = instr_word[INSTR_READ_BIT];
          nxt_cnt      = instr_word[INSTR_CNT_HI:INSTR_CNT_LO];
          nxt_addr     = instr_word[ADDR_W-1:0];
          nxt_done     = 2'h0;
          nxt_state    = ST_DATA;
          nxt_rd_word  = rd_load;
          nxt_rd_drive = instr_word[INSTR_READ_BIT] & ~four_wire;
        end
      end
      ST_DATA: begin
        if (byte_ev) begin
          nxt_addr = step_addr;
          nxt_done = (done_ff == 2'h3) ? done_ff : done_ff + 2'h1;
          if (xfer_last) begin
            nxt_state    = ST_INSTR_FIRST;
            nxt_rd_drive = 1'b0;
          end else begin
            nxt_rd_word  = rd_load;
          end
        end else if (burst_abort) begin
          nxt_state    = ST_INSTR_FIRST;
          nxt_rd_drive = 1'b0;
        end
      end
    endcase
  end

  // transfer state; a pause of a short transfer leaves it untouched
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_ff    <= ST_INSTR_FIRST;
      first_ff    <= 8'h00;
      dir_rd_ff   <= 1'b0;
      cnt_ff      <= 2'h0;
      addr_ff     <= 13'h0000;
      done_ff     <= 2'h0;
      rd_word_ff  <= 8'h00;
      rd_drive_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      first_ff    <= nxt_first;
      dir_rd_ff   <= nxt_dir_rd;
      cnt_ff      <= nxt_cnt;
      addr_ff     <= nxt_addr;
      done_ff     <= nxt_done;
      rd_word_ff  <= nxt_rd_word;
      rd_drive_ff <= nxt_rd_drive;
    end
  end

  // setup register; soft reset bit clears itself
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || soft_rst) begin
      port_setup_ff <= PORT_SETUP_RST;
      burst_end_ff  <= BURST_END_RST;
      out_fmt_ff    <= OUT_FORMAT_RST;
    end else begin
      if (hit_setup) begin
        port_setup_ff <= in_byte;
      end
      if (hit_burst) begin
        burst_end_ff <= in_byte;
      end
      if (hit_format) begin
        out_fmt_ff <= in_byte;
      end
    end
  end

  // power select survives soft reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      power_sel_ff <= POWER_SEL_RST;
    end else if (hit_power) begin
      power_sel_ff <= in_byte[2:0];
    end
  end

  // serial power choice wins over the tri-level pin
  assign nxt_power_state =
    (power_sel_ff == PWR_SEL_NORMAL) ? PWR_ST_NORMAL :
    (power_sel_ff == PWR_SEL_NAP)    ? PWR_ST_NAP :
    (power_sel_ff == PWR_SEL_SLEEP)  ? PWR_ST_SLEEP : pin_sync;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      power_state_ff <= PWR_ST_NORMAL;
    end else begin
      power_state_ff <= nxt_power_state;
    end
  end

  // pins: three-wire turns sdio, four-wire drives the dedicated output
  assign sdio_out                      = tx_bit;
  assign sdio_oe_n_out                 = ~link_drive;
  assign dedicated_serial_out_out      = tx_bit;
  assign dedicated_serial_out_oe_n_out = ~four_wire;
  assign power_state_out               = power_state_ff;
  assign output_format_out             = out_fmt_ff;

  a_setup_reset: assert property (
    @(posedge core_clk_in)
    !rst_n_in |=> (port_setup_ff == PORT_SETUP_RST) && !sdio_oe_n_out == 1'b0
  ) else $error("setup register not at default after reset");

  a_read_flag: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (state_ff == ST_INSTR_SECOND && byte_ev)
      |=> dir_rd_ff == $past(instr_word[15]) && state_ff == ST_DATA
  ) else $error("read flag not taken from leading bit");

  a_count_addr: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (state_ff == ST_INSTR_SECOND && byte_ev)
      |=> cnt_ff == $past(instr_word[14:13])
          && addr_ff == $past(instr_word[12:0]) && done_ff == 2'h0
  ) else $error("byte count or start address decoded wrongly");

  a_addr_step: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (state_ff == ST_DATA && byte_ev && !soft_rst)
      |=> addr_ff == ($past(lsb_first) ? $past(addr_ff) - 13'h0001
                                       : $past(addr_ff) + 13'h0001)
  ) else $error("address did not step by one");

  a_short_end: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (state_ff == ST_DATA && byte_ev && cnt_ff != 2'h3
      && done_ff == cnt_ff) |=> state_ff == ST_INSTR_FIRST && !rd_drive_ff
  ) else $error("short transfer ran past its byte count");

  a_pause_keep: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cs_rise && !byte_ev && cnt_ff != 2'h3)
      |=> $stable(state_ff) && $stable(addr_ff) && $stable(done_ff)
  ) else $error("short transfer lost state on pause");

  a_burst_abort: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (state_ff == ST_DATA && !byte_ev && burst_abort)
      |=> state_ff == ST_INSTR_FIRST ##1 state_ff == ST_INSTR_FIRST
  ) else $error("long transfer survived late deselect");

  a_power_wins: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (power_sel_ff == PWR_SEL_NAP) [*2] |-> power_state_out == PWR_ST_NAP
  ) else $error("pin overrode serial power mode");

  a_soft_keep: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    soft_rst |=> out_fmt_ff == OUT_FORMAT_RST
                 && power_sel_ff == $past(power_sel_ff)
                 && !port_setup_ff[PS_SOFT_RST_BIT]
  ) else $error("soft reset did not restore defaults");

  a_four_wire_out: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    four_wire |-> !dedicated_serial_out_oe_n_out && !rd_drive_ff
                  ##1 sdio_oe_n_out
  ) else $error("four-wire mode output enable wrong");

endmodule

// ---- tb/acs_spi_master.sv ----
// behavioural serial master for the configuration port
// assumes: bench resolves the shared data pin from the device enable
`timescale 1ns/1ps
module acs_spi_master (
  output logic      sclk_out,
  output logic      csn_out,
  output logic      mosi_out,
  output logic      mosi_oe_n_out,
  input  wire logic sdio_in,
  input  wire logic dso_in
);
  // half of a 160 ns link period, well under sample rate/16
  localparam real HALF_NS = 80.0;

  // idle: clock low, deselected, pin released
  initial begin
    sclk_out      = 1'b0;
    csn_out       = 1'b1;
    mosi_out      = 1'b0;
    mosi_oe_n_out = 1'b1;
  end

  // select with clock already low; odd offset keeps phase unrelated
  task automatic sel();
    #3.7;
    csn_out = 1'b0;
    #(HALF_NS);
  endtask

  // deselect, let go of the pin, show inverse of the last bit
  task automatic desel();
    #(HALF_NS);
    csn_out       = 1'b1;
    mosi_oe_n_out = 1'b1;
    mosi_out      = ~mosi_out;
    #(4 * HALF_NS);
  endtask

  // shift n bits, sampling each; lsb picks order, rd releases the pin
  task automatic shift(input logic [15:0] v, input int n,
                       input logic lsb, input logic rd,
                       input logic four, output logic [15:0] got);
    int k;
    got = 16'h0000;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      if (!rd) begin
        mosi_oe_n_out = 1'b0;
        mosi_out      = v[k];
      end else if (!mosi_oe_n_out) begin
        mosi_oe_n_out = 1'b1;
        mosi_out      = ~mosi_out;
      end
      #(HALF_NS);
      sclk_out = 1'b1;
      got[k]   = four ? dso_in : sdio_in;
      #(HALF_NS);
      sclk_out = 1'b0;
    end
  endtask
endmodule

// ---- tb/acs_core_tb.sv ----
// self-checking bench for the serial configuration port
// assumes: master model clocks the link only inside frames
`timescale 1ns/1ps
module acs_core_tb;
  import acs_pkg::*;

  logic        core_clk;
  logic        rst_n;
  logic [1:0]  pin_mode;
  logic        sclk, csn, mosi, mosi_oe_n, sdio_line;
  logic        sdio_out, sdio_oe_n, dso, dso_oe_n;
  logic [1:0]  pwr_state;
  logic [7:0]  fmt;
  logic [15:0] got;
  int          num_errors, checked, cycles, drv_cnt, mark;

  // core clock 200 MHz
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // shared data pin: device level when it drives, else master
  assign sdio_line = (sdio_oe_n === 1'b0) ? sdio_out : mosi;

  acs_core acs_core_inst (
    .core_clk_in                   (core_clk),
    .rst_n_in                      (rst_n),
    .link_sclk_in                  (sclk),
    .chip_select_n_in              (csn),
    .sdio_in                       (sdio_line),
    .sdio_out                      (sdio_out),
    .sdio_oe_n_out                 (sdio_oe_n),
    .dedicated_serial_out_out      (dso),
    .dedicated_serial_out_oe_n_out (dso_oe_n),
    .power_mode_pin_in             (pin_mode),
    .power_state_out               (pwr_state),
    .output_format_out             (fmt)
  );

  acs_spi_master acs_spi_master_inst (
    .sclk_out      (sclk),
    .csn_out       (csn),
    .mosi_out      (mosi),
    .mosi_oe_n_out (mosi_oe_n),
    .sdio_in       (sdio_line),
    .dso_in        (dso)
  );

  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // drive count, pin contention and timeout watch
  always @(posedge core_clk) begin
    cycles++;
    if (sdio_oe_n === 1'b0) drv_cnt++;
    if (sdio_oe_n === 1'b0 && mosi_oe_n === 1'b0) begin
      chk("contention", 8'h00, 8'h01);
    end
    if (cycles == 80000) begin
      chk("timeout", 8'h00, 8'h01);
      report_and_stop();
    end
  end

  // link access helpers
  task automatic settle();
    repeat (20) @(negedge core_clk);
  endtask
  task automatic instr(input logic rw, input logic [1:0] cnt,
                       input logic [12:0] a, input logic lsb);
    acs_spi_master_inst.shift({rw, cnt, a}, 16, lsb, 1'b0, 1'b0, got);
  endtask
  task automatic wbyte(input logic [7:0] d, input logic lsb);
    acs_spi_master_inst.shift({8'h00, d}, 8, lsb, 1'b0, 1'b0, got);
  endtask
  task automatic rbyte(input logic lsb, input logic four);
    acs_spi_master_inst.shift(16'h0000, 8, lsb, 1'b1, four, got);
  endtask
  task automatic wr1(input logic [12:0] a, input logic [7:0] d,
                     input logic lsb);
    acs_spi_master_inst.sel();
    instr(1'b0, 2'b00, a, lsb);
    wbyte(d, lsb);
    acs_spi_master_inst.desel();
    settle();
  endtask
  task automatic rd1(input string name, input logic [12:0] a,
                     input logic lsb, input logic four,
                     input logic [7:0] exp);
    acs_spi_master_inst.sel();
    instr(1'b1, 2'b00, a, lsb);
    rbyte(lsb, four);
    acs_spi_master_inst.desel();
    chk(name, exp, got[7:0]);
  endtask

  // main sequence
  initial begin
    rst_n      = 1'b0;
    pin_mode   = 2'b01;
    num_errors = 0;
    checked    = 0;
    cycles     = 0;
    drv_cnt    = 0;
    got        = 16'h0000;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("pwr_pin", {6'h00, PWR_ST_SLEEP}, {6'h00, pwr_state});
    chk("fmt_rst", OUT_FORMAT_RST, fmt);
    chk("dso_off", 8'h01, {7'h00, dso_oe_n});
    mark = drv_cnt;
    rd1("setup_rst", ADDR_PORT_SETUP, 1'b0, 1'b0, PORT_SETUP_RST);
    chk("sdio_drove", 8'h01, {7'h00, drv_cnt > mark});
    // burst read over three places, closed by deselect
    acs_spi_master_inst.sel();
    instr(1'b1, CNT_BURST, ADDR_PORT_SETUP, 1'b0);
    rbyte(1'b0, 1'b0);
    chk("burst0", PORT_SETUP_RST, got[7:0]);
    rbyte(1'b0, 1'b0);
    chk("burst1", UNMAPPED_READ, got[7:0]);
    rbyte(1'b0, 1'b0);
    chk("burst2", BURST_END_RST, got[7:0]);
    acs_spi_master_inst.desel();
    // three-byte write paused at every boundary, last lands at 0x25
    acs_spi_master_inst.sel();
    instr(1'b0, 2'b10, 13'h0023, 1'b0);
    acs_spi_master_inst.desel();
    acs_spi_master_inst.sel();
    wbyte(8'h77, 1'b0);
    acs_spi_master_inst.desel();
    acs_spi_master_inst.sel();
    wbyte(8'h77, 1'b0);
    acs_spi_master_inst.desel();
    acs_spi_master_inst.sel();
    wbyte({5'h00, PWR_SEL_NAP}, 1'b0);
    acs_spi_master_inst.desel();
    settle();
    chk("pwr_nap", {6'h00, PWR_ST_NAP}, {6'h00, pwr_state});
    // burst write paused before data, then cut by deselect
    acs_spi_master_inst.sel();
    instr(1'b0, CNT_BURST, 13'h0072, 1'b0);
    acs_spi_master_inst.desel();
    acs_spi_master_inst.sel();
    wbyte(8'h11, 1'b0);
    wbyte(8'hA5, 1'b0);
    acs_spi_master_inst.desel();
    settle();
    chk("fmt_a5", 8'hA5, fmt);
    rd1("fmt_rd", ADDR_OUT_FORMAT, 1'b0, 1'b0, 8'hA5);
    // lsb-first with mirrored nibbles; address steps down
    wr1(ADDR_PORT_SETUP, 8'h5A, 1'b0);
    acs_spi_master_inst.sel();
    instr(1'b0, 2'b01, ADDR_OUT_FORMAT, 1'b1);
    wbyte(8'hC3, 1'b1);
    wbyte(8'h3C, 1'b1);
    acs_spi_master_inst.desel();
    settle();
    chk("fmt_lsb", 8'hC3, fmt);
    rd1("fmt_lsb_rd", ADDR_OUT_FORMAT, 1'b1, 1'b0, 8'hC3);
    // soft reset written in lsb order; power select survives
    wr1(ADDR_PORT_SETUP, 8'h30, 1'b1);
    chk("fmt_srst", OUT_FORMAT_RST, fmt);
    rd1("setup_srst", ADDR_PORT_SETUP, 1'b0, 1'b0, PORT_SETUP_RST);
    rd1("pwr_kept", ADDR_POWER_SEL, 1'b0, 1'b0, {5'h00, PWR_SEL_NAP});
    @(negedge core_clk);
    pin_mode = 2'b00;
    repeat (10) @(negedge core_clk);
    chk("pwr_over", {6'h00, PWR_ST_NAP}, {6'h00, pwr_state});
    // remaining serial power codes, sleep and normal, then back to pin control
    wr1(ADDR_POWER_SEL, {5'h00, PWR_SEL_SLEEP}, 1'b0);
    chk("pwr_sleep", {6'h00, PWR_ST_SLEEP}, {6'h00, pwr_state});
    pin_mode = 2'b10;
    wr1(ADDR_POWER_SEL, {5'h00, PWR_SEL_NORMAL}, 1'b0);
    chk("pwr_normal", {6'h00, PWR_ST_NORMAL}, {6'h00, pwr_state});
    wr1(ADDR_POWER_SEL, {5'h00, PWR_SEL_PIN}, 1'b0);
    chk("pwr_pin_nap", {6'h00, PWR_ST_NAP}, {6'h00, pwr_state});
    // four-wire read on the dedicated pin, data pin quiet
    wr1(ADDR_OUT_FORMAT, 8'h96, 1'b0);
    wr1(ADDR_PORT_SETUP, 8'h99, 1'b0);
    chk("dso_on", 8'h00, {7'h00, dso_oe_n});
    mark = drv_cnt;
    rd1("four_wire", ADDR_OUT_FORMAT, 1'b0, 1'b1, 8'h96);
    chk("sdio_quiet", 8'h00, {7'h00, drv_cnt != mark});
    wr1(ADDR_PORT_SETUP, 8'h3C, 1'b0);
    chk("dso_back", 8'h01, {7'h00, dso_oe_n});
    report_and_stop();
  end
endmodule
